// file: logic/bps_consts.vh
/*
 Constants of the broadband symbol control block: register map,
 field positions, reset values, symbol codes and timing counts.
 Assumes a 250 MHz pclk; included by bps_symbol_ctl.v.
*/
`ifndef BPS_CONSTS_VH
`define BPS_CONSTS_VH

// Register byte offsets
`define BPS_CTRL_OFS    8'h00
`define BPS_SIGT_OFS    8'h04
`define BPS_STAT_OFS    8'h08
`define BPS_PHASE_OFS   8'h0c
`define BPS_LEVEL_OFS   8'h10

// Control fields and register reset values
`define BPS_CTRL_REMOD  0
`define BPS_CTRL_SRC_LO 1
`define BPS_CTRL_SRC_HI 2
`define BPS_CTRL_CHG    3
`define BPS_CTRL_EN_LO  4
`define BPS_CTRL_EN_HI  5
`define BPS_CTRL_JCLR   6
`define BPS_CTRL_RST    32'h0000_0000
`define BPS_PHASE_RST   4'h2
`define BPS_LEVEL_RST   8'h88

// Receive source selection
`define BPS_SRC_MED_A   2'h0
`define BPS_SRC_MED_B   2'h1
`define BPS_SRC_LOOP    2'h2

// MAC-symbol codes
`define BPS_M_SIL       3'h0
`define BPS_M_ZERO      3'h1
`define BPS_M_ONE       3'h2
`define BPS_M_NDATA     3'h3
`define BPS_M_PAD       3'h4
`define BPS_M_BAD       3'h5

// PHY-symbol codes: {0}, {2}, {4}, and an illegal level
`define BPS_P0          2'h0
`define BPS_P2          2'h1
`define BPS_P4          2'h2
`define BPS_PILL        2'h3

// Pseudo-silence patterns, symbol i in bits 2i+1:2i
`define BPS_PS_BASIC    16'h1111
`define BPS_PS_EXT      16'h0211
`define BPS_PS_LEN_B    4'h2
`define BPS_PS_LEN_E    4'h8

// Timing
`define BPS_CLK_NS      4
`define BPS_SYM_DIV     5'h19
`define BPS_JAB_MS      500
`define BPS_JAB_CYC     (`BPS_JAB_MS * 1000000 / `BPS_CLK_NS)
`define BPS_HOLD_US     5000
`define BPS_HOLD_CYC    ((`BPS_HOLD_US * 1000 + `BPS_CLK_NS - 1) / `BPS_CLK_NS)
`define BPS_TRAIN_SYM   5'h1c

`endif

// file: logic/bps_symbol_ctl.v
/*
 Broadband token-bus PHY symbol control: receive decoding, symbol
 timing, transmit encoding and gating, jabber watch, APB registers.
 Assumes a modem front end giving one receive strobe per recovered
 symbol on each medium, and a MAC that supplies a symbol per take.
*/
`timescale 1ns/1ps
`include "bps_consts.vh"

module bps_symbol_ctl #(
  parameter [27:0] JAB_CYC  = `BPS_JAB_CYC,
  parameter [21:0] HOLD_CYC = `BPS_HOLD_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  mac_tx_sym,
  input  wire        mac_orig,
  output reg         mac_tx_take,
  output reg  [2:0]  mac_rx_sym,
  output reg         mac_rx_stb,
  input  wire [3:0]  phy_rx_sym,
  input  wire [1:0]  phy_rx_stb,
  input  wire [1:0]  phy_mod,
  input  wire [1:0]  phy_ovld,
  output reg  [1:0]  phy_tx_sym,
  output reg         phy_tx_stb,
  output reg  [1:0]  phy_tx_on,
  output reg  [7:0]  phy_tx_lvl,
  output reg         tx_inhibit
);

  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  reg  [1:0]  st_reg;
  reg  [21:0] hold_reg;
  reg         remod_reg;
  reg  [1:0]  src_reg;
  reg         chg_reg;
  reg  [1:0]  en_reg;
  reg  [3:0]  phase_reg;
  reg         type_reg;
  reg         req_reg;
  reg  [4:0]  div_reg;
  reg  [15:0] dly_reg;
  reg  [4:0]  meas_reg;
  reg         mod_d_reg;
  reg  [4:0]  train_reg;
  reg  [2:0]  tx_idx_reg;
  reg  [2:0]  rx_idx_reg;
  reg  [3:0]  run_reg;
  reg  [1:0]  jab_reg;
  reg  [1:0]  tx_sym_next;
  reg  [2:0]  rx_sym_next;
  reg  [31:0] rd_next;
  reg         hit_next;

  wire        acc   = psel & penable & pready;
  wire        wr    = acc & pwrite & ~pslverr;
  wire        jclr  = wr & (paddr == `BPS_CTRL_OFS) & pwdata[`BPS_CTRL_JCLR];
  wire        loop  = (remod_reg & mac_orig) | (src_reg == `BPS_SRC_LOOP);
  wire        sel_b = (src_reg == `BPS_SRC_MED_B);
  wire [1:0]  rsym  = sel_b ? phy_rx_sym[3:2] : phy_rx_sym[1:0];
  wire        rstb  = sel_b ? phy_rx_stb[1] : phy_rx_stb[0];
  wire        rmod  = sel_b ? phy_mod[1] : phy_mod[0];
  wire        rovl  = sel_b ? phy_ovld[1] : phy_ovld[0];
  wire        div_t = (div_reg == `BPS_SYM_DIV - 5'h01);
  wire        tick  = remod_reg ? div_t : dly_reg[phase_reg];
  wire        rtick = loop ? tick : rstb;
  wire [15:0] pat   = type_reg ? `BPS_PS_EXT : `BPS_PS_BASIC;
  wire [3:0]  plen  = type_reg ? `BPS_PS_LEN_E : `BPS_PS_LEN_B;
  wire        inh   = chg_reg | (src_reg == `BPS_SRC_LOOP) | st_reg[1];
  wire        sil   = (mac_tx_sym == `BPS_M_SIL);
  wire        tx_go = remod_reg | ~sil;

  function [1:0] pat_sym;
    input [15:0] p;
    input [2:0]  i;
    begin
      pat_sym = p[{i, 1'b0} +: 2];
    end
  endfunction

  wire [2:0]  rx_last = (plen == `BPS_PS_LEN_E) ? 3'h7 : 3'h1;
  wire        rx_hit  = (rsym == pat_sym(pat, rx_idx_reg));

  // APB register write and signalling-type change sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remod_reg <= 1'b0;
      src_reg   <= `BPS_SRC_MED_A;
      chg_reg   <= 1'b0;
      en_reg    <= 2'b00;
      phase_reg <= `BPS_PHASE_RST;
      phy_tx_lvl <= `BPS_LEVEL_RST;
      req_reg   <= 1'b0;
      type_reg  <= 1'b0;
      st_reg    <= ST_RUN;
      hold_reg  <= 22'h0;
    end else begin
      if (wr && paddr == `BPS_CTRL_OFS) begin
        remod_reg <= pwdata[`BPS_CTRL_REMOD];
        src_reg   <= pwdata[`BPS_CTRL_SRC_HI:`BPS_CTRL_SRC_LO];
        chg_reg   <= pwdata[`BPS_CTRL_CHG];
        en_reg    <= pwdata[`BPS_CTRL_EN_HI:`BPS_CTRL_EN_LO];
      end
      if (wr && paddr == `BPS_PHASE_OFS)
        phase_reg <= pwdata[3:0];
      if (wr && paddr == `BPS_LEVEL_OFS)
        phy_tx_lvl <= pwdata[7:0];
      if (wr && paddr == `BPS_SIGT_OFS)
        req_reg <= pwdata[0];
      case (st_reg)
        ST_RUN: begin
          if (wr && paddr == `BPS_SIGT_OFS && pwdata[0] != type_reg) begin
            st_reg   <= ST_HOLD;
            hold_reg <= 22'h0;
          end
        end
        ST_HOLD: begin
          if (hold_reg == HOLD_CYC - 22'h1) begin
            type_reg <= req_reg;
            st_reg   <= ST_RUN;
          end else begin
            hold_reg <= hold_reg + 22'h1;
          end
        end
        default: st_reg <= ST_RUN;
      endcase
    end
  end

  // APB read data and decode
  always @* begin
    rd_next  = 32'h0;
    hit_next = 1'b1;
    case (paddr)
      `BPS_CTRL_OFS:  rd_next = {26'h0, en_reg, chg_reg, src_reg, remod_reg};
      `BPS_SIGT_OFS:  rd_next = {31'h0, req_reg};
      `BPS_STAT_OFS:  rd_next = {19'h0, meas_reg, train_reg == `BPS_TRAIN_SYM,
                                 jab_reg, st_reg[1], mac_orig, type_reg, inh,
                                 tx_inhibit};
      `BPS_PHASE_OFS: rd_next = {28'h0, phase_reg};
      `BPS_LEVEL_OFS: rd_next = {24'h0, phy_tx_lvl};
      default:        hit_next = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_next;
      if (psel && !penable)
        prdata <= pwrite ? 32'h0 : rd_next;
    end
  end

  // Symbol timing: own divider or delayed recovered strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg   <= 5'h0;
      dly_reg   <= 16'h0;
      meas_reg  <= 5'h0;
      mod_d_reg <= 1'b0;
      train_reg <= 5'h0;
    end else begin
      div_reg   <= div_t ? 5'h0 : div_reg + 5'h01;
      dly_reg   <= {dly_reg[14:0], rstb};
      mod_d_reg <= rmod;
      if (rmod && !mod_d_reg)
        meas_reg <= div_reg;
      if (!rmod || !remod_reg)
        train_reg <= 5'h0;
      else if (rstb && train_reg != `BPS_TRAIN_SYM)
        train_reg <= train_reg + 5'h01;
    end
  end

  // Transmit encoding
  always @* begin
    case (mac_tx_sym)
      `BPS_M_ZERO:  tx_sym_next = `BPS_P0;
      `BPS_M_ONE:   tx_sym_next = `BPS_P4;
      `BPS_M_PAD:   tx_sym_next = `BPS_P4;
      `BPS_M_NDATA: tx_sym_next = `BPS_P2;
      `BPS_M_SIL:   tx_sym_next = remod_reg ? pat_sym(pat, tx_idx_reg) : `BPS_P0;
      default:      tx_sym_next = `BPS_P2;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_tx_sym  <= `BPS_P0;
      phy_tx_stb  <= 1'b0;
      mac_tx_take <= 1'b0;
      tx_idx_reg  <= 3'h0;
      tx_inhibit  <= 1'b0;
    end else begin
      phy_tx_stb  <= tick;
      mac_tx_take <= tick;
      tx_inhibit  <= inh | (|jab_reg);
      if (tick) begin
        phy_tx_sym <= tx_sym_next;
        if (!sil)
          tx_idx_reg <= 3'h0;
        else if ({1'b0, tx_idx_reg} == plen - 4'h1)
          tx_idx_reg <= 3'h0;
        else
          tx_idx_reg <= tx_idx_reg + 3'h1;
      end
    end
  end

  // Per-medium transmit gate and jabber watch
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : med
      reg [27:0] jcnt_reg;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          jcnt_reg     <= 28'h0;
          jab_reg[g]   <= 1'b0;
          phy_tx_on[g] <= 1'b0;
        end else begin
          if (tick)
            phy_tx_on[g] <= en_reg[g] & ~inh & ~jab_reg[g] & tx_go;
          else if (inh || jab_reg[g] || !en_reg[g])
            phy_tx_on[g] <= 1'b0;
          if (!phy_tx_on[g] || remod_reg)
            jcnt_reg <= 28'h0;
          else if (jcnt_reg != JAB_CYC)
            jcnt_reg <= jcnt_reg + 28'h1;
          if (!remod_reg && jcnt_reg == JAB_CYC)
            jab_reg[g] <= 1'b1;
          else if (jclr)
            jab_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Receive decoding
  always @* begin
    if (loop)
      rx_sym_next = mac_tx_sym;
    else if (!rmod)
      rx_sym_next = remod_reg ? `BPS_M_SIL : `BPS_M_BAD;
    else if (remod_reg && rovl)
      rx_sym_next = `BPS_M_BAD;
    else if (rsym == `BPS_PILL)
      rx_sym_next = `BPS_M_BAD;
    else if (!remod_reg && rx_hit && run_reg >= plen)
      rx_sym_next = `BPS_M_SIL;
    else if (rsym == `BPS_P0)
      rx_sym_next = `BPS_M_ZERO;
    else if (rsym == `BPS_P4)
      rx_sym_next = `BPS_M_ONE;
    else
      rx_sym_next = `BPS_M_NDATA;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rx_sym <= `BPS_M_SIL;
      mac_rx_stb <= 1'b0;
      rx_idx_reg <= 3'h0;
      run_reg    <= 4'h0;
    end else begin
      mac_rx_stb <= rtick & ~chg_reg;
      if (rtick && !chg_reg)
        mac_rx_sym <= rx_sym_next;
      if (rstb && !loop) begin
        if (!rmod || rsym == `BPS_PILL) begin
          rx_idx_reg <= 3'h0;
          run_reg    <= 4'h0;
        end else if (rx_hit) begin
          rx_idx_reg <= (rx_idx_reg == rx_last) ? 3'h0 : rx_idx_reg + 3'h1;
          if (run_reg != 4'hf)
            run_reg <= run_reg + 4'h1;
        end else begin
          rx_idx_reg <= (rsym == pat_sym(pat, 3'h0)) ? 3'h1 : 3'h0;
          run_reg    <= (rsym == pat_sym(pat, 3'h0)) ? 4'h1 : 4'h0;
        end
      end
    end
  end

endmodule

// file: bench/bps_far_model.sv
/* Modem front end and MAC model for the symbol control block.
   Assumes the bench asks for each receive symbol with a one-cycle go. */
`timescale 1ns/1ps
`include "bps_consts.vh"
module bps_far_model (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       go,
  input  logic [3:0] sym,
  input  logic [2:0] want,
  input  logic       mac_tx_take,
  output logic [1:0] phy_rx_stb,
  output logic [3:0] phy_rx_sym,
  output logic [2:0] mac_tx_sym
);
  logic [5:0] pre_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_rx_stb <= 2'h0;
      phy_rx_sym <= 4'h0;
    end else begin
      phy_rx_stb <= {2{go}};
      phy_rx_sym <= go ? sym : ~phy_rx_sym;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_reg <= 6'h0;
    else if (want == `BPS_M_SIL)
      pre_reg <= 6'h0;
    else if (mac_tx_take && pre_reg < 6'd32)
      pre_reg <= pre_reg + 6'h1;
  end
  // Preamble of pad_idle after silence
  assign mac_tx_sym = (want != `BPS_M_SIL && pre_reg < 6'd32) ? `BPS_M_PAD : want;
endmodule

// file: bench/bps_symbol_ctl_sva.sv
/* Checker for the symbol control block, bound to its ports.
   Assumes PHASE stays at its reset value; shadows CTRL from APB writes. */
`timescale 1ns/1ps
`include "bps_consts.vh"
module bps_chk #(
  parameter [27:0] JAB_CYC = 28'd200
) (
  input logic        pclk,
  input logic        presetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic        mac_tx_take,
  input logic [2:0]  mac_rx_sym,
  input logic        mac_rx_stb,
  input logic [3:0]  phy_rx_sym,
  input logic [1:0]  phy_rx_stb,
  input logic [1:0]  phy_mod,
  input logic        phy_tx_stb,
  input logic [1:0]  phy_tx_on
);
  logic [6:0]  c_reg;
  logic [27:0] jc_reg;
  wire nr = !c_reg[0] && c_reg[2:1] == `BPS_SRC_MED_A && !c_reg[3];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      c_reg <= 7'h0;
    else if (psel && penable && pwrite && paddr == `BPS_CTRL_OFS)
      c_reg <= pwdata[6:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      jc_reg <= 28'h0;
    else if (c_reg[0] || !phy_tx_on[0])
      jc_reg <= 28'h0;
    else
      jc_reg <= jc_reg + 28'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rx(logic m, logic [1:0] p);
    nr && phy_rx_stb[0] && phy_mod[0] == m && phy_rx_sym[1:0] == p;
  endsequence
  sequence s_bad;
    mac_rx_stb && mac_rx_sym == `BPS_M_BAD;
  endsequence
  property p_take; mac_tx_take |-> phy_tx_stb; endproperty
  property p_phase; nr && phy_rx_stb[0] |-> ##4 phy_tx_stb; endproperty
  property p_tick; c_reg[0] && $past(c_reg[0]) && phy_tx_stb |-> ##25 (phy_tx_stb || !c_reg[0]);
  endproperty
  property p_nomod; s_rx(1'b0, `BPS_P4) |=> s_bad; endproperty
  property p_ill; s_rx(1'b1, `BPS_PILL) |=> s_bad; endproperty
  property p_one; s_rx(1'b1, `BPS_P4) |=> mac_rx_stb && mac_rx_sym == `BPS_M_ONE; endproperty
  property p_en; (phy_tx_on & ~$past(c_reg[5:4])) == 2'h0; endproperty
  property p_loop; $past(c_reg[2:1]) == `BPS_SRC_LOOP |-> phy_tx_on == 2'h0; endproperty
  property p_chg; $past(c_reg[3]) |-> !mac_rx_stb && phy_tx_on == 2'h0; endproperty
  property p_jab; jc_reg <= JAB_CYC + 28'd3; endproperty
  a_take: assert property (p_take) else $error("take without tx strobe");
  a_phase: assert property (p_phase) else $error("tx strobe phase wrong");
  a_tick: assert property (p_tick) else $error("tx tick period wrong");
  a_nomod: assert property (p_nomod) else $error("no modulation not bad");
  a_ill: assert property (p_ill) else $error("illegal symbol not bad");
  a_one: assert property (p_one) else $error("level four not one");
  a_en: assert property (p_en) else $error("tx on while disabled");
  a_loop: assert property (p_loop) else $error("tx on in loopback");
  a_chg: assert property (p_chg) else $error("activity in channel change");
  a_jab: assert property (p_jab) else $error("jabber did not stop tx");
endmodule
bind bps_symbol_ctl bps_chk #(.JAB_CYC(JAB_CYC)) i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .mac_tx_take(mac_tx_take), .mac_rx_sym(mac_rx_sym),
  .mac_rx_stb(mac_rx_stb), .phy_rx_sym(phy_rx_sym), .phy_rx_stb(phy_rx_stb),
  .phy_mod(phy_mod), .phy_tx_stb(phy_tx_stb), .phy_tx_on(phy_tx_on)
);

// file: bench/test_broadband_phy_symbol_control.sv
/* Testbench for the symbol control block with modem and MAC model.
   Assumes jabber and hold counts shortened to 200 and 50 cycles. */
`timescale 1ns/1ps
`include "bps_consts.vh"
module test_broadband_phy_symbol_control;
  logic        pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, mac_orig = 0;
  logic        go = 0, watch = 0, mac_tx_take, mac_rx_stb, phy_tx_stb, pready;
  logic        pslverr, tx_inhibit, rd_e;
  logic [7:0]  paddr = 0, phy_tx_lvl;
  logic [31:0] pwdata = 0, prdata, rd_v, d, seed = 32'ha349b1a0;
  logic [3:0]  sym = 0, phy_rx_sym;
  logic [2:0]  want = 0, mac_tx_sym, mac_rx_sym, exp_q[$];
  logic [1:0]  phy_rx_stb, phy_mod = 0, phy_tx_sym, phy_tx_on, r;
  int          n_mismatch = 0, n_compared = 0;
  bps_symbol_ctl #(.JAB_CYC(28'd200), .HOLD_CYC(22'd50)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_tx_sym(mac_tx_sym), .mac_orig(mac_orig), .mac_tx_take(mac_tx_take),
    .mac_rx_sym(mac_rx_sym), .mac_rx_stb(mac_rx_stb), .phy_rx_sym(phy_rx_sym),
    .phy_rx_stb(phy_rx_stb), .phy_mod(phy_mod), .phy_ovld(2'h0), .phy_tx_sym(phy_tx_sym),
    .phy_tx_stb(phy_tx_stb), .phy_tx_on(phy_tx_on), .phy_tx_lvl(phy_tx_lvl),
    .tx_inhibit(tx_inhibit));
  bps_far_model i_far (.pclk(pclk), .presetn(presetn), .go(go), .sym(sym), .want(want),
    .mac_tx_take(mac_tx_take), .phy_rx_stb(phy_rx_stb), .phy_rx_sym(phy_rx_sym),
    .mac_tx_sym(mac_tx_sym));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_mismatch++;
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wstb();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (phy_tx_stb !== 1'b1 && k < 100);
    if (phy_tx_stb !== 1'b1)
      n_mismatch++;
  endtask
  task automatic send(input logic [1:0] p, input logic [2:0] e, input logic q);
    if (q)
      exp_q.push_back(e);
    sym <= {p, p};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (25) @(posedge pclk);
  endtask
  task automatic cap(input int n, input logic [15:0] pat);
    for (int i = 0; i < n; i++) begin
      wstb();
      chk("phy_tx_sym", 32'(pat[2*i+:2]), 32'(phy_tx_sym));
      chk("phy_tx_on", 32'h1, 32'(phy_tx_on));
      chk("loopback rx", 32'h8, 32'({mac_rx_stb, mac_rx_sym}));
    end
  endtask
  task final_report;
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (watch && mac_rx_stb === 1'b1) begin
      if (exp_q.size() == 0)
        chk("mac_rx_stb", 32'h0, 32'h1);
      else
        chk("mac_rx_sym", 32'(exp_q.pop_front()), 32'(mac_rx_sym));
    end
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `BPS_CTRL_OFS, 0);
    chk("ctrl", `BPS_CTRL_RST, rd_v);
    apb(0, `BPS_PHASE_OFS, 0);
    chk("phase", 32'(`BPS_PHASE_RST), rd_v);
    apb(0, `BPS_LEVEL_OFS, 0);
    chk("level", 32'(`BPS_LEVEL_RST), rd_v);
    apb(0, 8'h14, 0);
    chk("pslverr", 32'h1, 32'(rd_e));
    d = xs();
    apb(1, `BPS_LEVEL_OFS, d);
    chk("phy_tx_lvl", 32'(d[7:0]), 32'(phy_tx_lvl));
    $display("Test registers done");
    phy_mod <= 2'h3;
    watch <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      d = xs();
      r = 2'(d % 3);
      send(r == 0 ? `BPS_P0 : r == 1 ? `BPS_P4 : `BPS_PILL,
           r == 0 ? `BPS_M_ZERO : r == 1 ? `BPS_M_ONE : `BPS_M_BAD, 1'b1);
    end
    send(`BPS_P4, `BPS_M_ONE, 1'b1);
    send(`BPS_P2, `BPS_M_NDATA, 1'b1);
    phy_mod <= 2'h0;
    send(`BPS_P4, `BPS_M_BAD, 1'b1);
    phy_mod <= 2'h3;
    send(`BPS_P2, `BPS_M_NDATA, 1'b1);
    send(`BPS_P0, `BPS_M_ZERO, 1'b1);
    send(`BPS_P2, `BPS_M_SIL, 1'b1);
    send(`BPS_P0, `BPS_M_SIL, 1'b1);
    apb(1, `BPS_CTRL_OFS, 32'h18);
    send(`BPS_P4, 0, 1'b0);
    chk("phy_tx_on", 32'h0, 32'(phy_tx_on));
    chk("rx pending", 32'h0, 32'(exp_q.size()));
    watch <= 1'b0;
    $display("Test receive done");
    want <= `BPS_M_ONE;
    apb(1, `BPS_CTRL_OFS, 32'h10);
    repeat (12) send(`BPS_P4, 0, 1'b0);
    apb(0, `BPS_STAT_OFS, 0);
    chk("stat jabber", 32'h21, rd_v & 32'h21);
    chk("tx_inhibit", 32'h1, 32'(tx_inhibit));
    want <= `BPS_M_SIL;
    apb(1, `BPS_CTRL_OFS, 32'h50);
    apb(0, `BPS_STAT_OFS, 0);
    chk("stat jabber", 32'h0, rd_v & 32'h20);
    want <= `BPS_M_ONE;
    apb(1, `BPS_CTRL_OFS, 32'h14);
    send(`BPS_P4, 0, 1'b0);
    chk("phy_tx_on", 32'h0, 32'(phy_tx_on));
    $display("Test station transmit done");
    mac_orig <= 1'b1;
    apb(1, `BPS_CTRL_OFS, 32'h11);
    wstb();
    want <= `BPS_M_SIL;
    cap(4, `BPS_PS_BASIC);
    apb(1, `BPS_SIGT_OFS, 32'h1);
    @(posedge pclk);
    chk("phy_tx_on", 32'h0, 32'(phy_tx_on));
    repeat (60) @(posedge pclk);
    apb(0, `BPS_STAT_OFS, 0);
    chk("stat type", 32'h4, rd_v & 32'h14);
    want <= `BPS_M_ONE;
    wstb();
    want <= `BPS_M_SIL;
    cap(8, `BPS_PS_EXT);
    $display("Test remodulator done");
    final_report();
  end
endmodule
